// ==== core/pwg_pkg.sv ====
// constants and types shared by the pwm/pdm generator
package pwg_pkg;
	// clock and base tick timing
	localparam int CLK_NS      = 10;
	localparam int TICK_NS     = 10000;
	localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
	localparam int SLOW_NS     = 1000000;
	localparam int SLOW_TICKS  = SLOW_NS / TICK_NS;
	localparam int TICK_HZ     = 1000000000 / TICK_NS;
	localparam int FREQ_MAX_HZ = TICK_HZ / 2;
	// data widths and fixed point layout
	localparam int CMD_W    = 16;
	localparam int SCALE_W  = 16;
	localparam int FREQ_W   = 24;
	localparam int DUTY_W   = 17;
	localparam int PER_W    = 24;
	localparam int PER_FRAC = 8;
	localparam int DIV_W    = 32;
	localparam logic [16:0] DUTY_ONE = 17'h10000;
	// output styles
	localparam logic [1:0] STYLE_PWM     = 2'h0;
	localparam logic [1:0] STYLE_PWM_DIR = 2'h1;
	localparam logic [1:0] STYLE_UPDN    = 2'h2;
	// slow update sequencer
	typedef enum logic [2:0] {S_IDLE, S_DUTY, S_PER, S_FREQ, S_RB, S_NEXT} pwg_slow_t;
endpackage

// ==== core/pwg_divider.sv ====
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/1ns
module pwg_divider #(
	parameter int W = 32
) (
	input  wire logic         mclk_in,
	input  wire logic         reset_n_in,
	input  wire logic         start_in,
	input  wire logic [W-1:0] num_in,
	input  wire logic [W-1:0] den_in,
	output logic              done_out,
	output logic [W-1:0]      quot_out
);
	logic [W:0]   rem_reg;
	logic [7:0]   cnt_reg;
	logic         busy_reg;
	logic [W-1:0] den_reg;
	logic [W:0]   rem_sh;

	// shifted partial remainder
	assign rem_sh = {rem_reg[W-1:0], quot_out[W-1]};

	// one bit per cycle; a zero divisor yields all ones
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rem_reg  <= '0;
			cnt_reg  <= 8'h00;
			busy_reg <= 1'b0;
			den_reg  <= '0;
			quot_out <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (start_in) begin
				rem_reg  <= '0;
				quot_out <= num_in;
				den_reg  <= den_in;
				cnt_reg  <= 8'(W);
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (rem_sh >= {1'b0, den_reg}) begin
					rem_reg  <= rem_sh - {1'b0, den_reg};
					quot_out <= {quot_out[W-2:0], 1'b1};
				end else begin
					rem_reg  <= rem_sh;
					quot_out <= {quot_out[W-2:0], 1'b0};
				end
				cnt_reg <= cnt_reg - 8'h01;
				if (cnt_reg == 8'h01) begin
					busy_reg <= 1'b0;
					done_out <= 1'b1;
				end
			end
		end
	end
endmodule // pwg_divider

// ==== core/pwg_pwm_pdm_gen.sv ====
// multi-channel pwm/pdm generator with direction and up/down styles
// Function
// - single-pin style: negative command counts as zero
// - pwm-dir style: magnitude modulates, dir high negative
// - up/down style: sign picks which pin modulates
// - duty equals command divided by scale
// - zero frequency request selects pulse density
// - frequency above internal maximum is clamped
// - no dither: frequency snapped to whole tick periods
// - dither: fractional period and high time accumulate
// - no dither: duty and frequency exactly tick-achievable
// - enabled duty raised to floor
// - duty clamped to ceiling
// - disabled channel has zero duty
// - effective duty read back per channel
// - modulation level only changes on a base tick; enable and style act on the pins one clock later
// - slow update computes period and high tick counts
// - each output exists only in its styles
// - eight channels share fast and slow events
`timescale 1ns/1ns
module pwg_pwm_pdm_gen #(
	parameter int NUM_CH     = 8,
	parameter int SLOW_TICKS = pwg_pkg::SLOW_TICKS
) (
	input  wire logic                                     mclk_in,
	input  wire logic                                     reset_n_in,
	input  wire logic [NUM_CH-1:0]                        enable_in,
	input  wire logic [NUM_CH-1:0][1:0]                   style_in,
	input  wire logic [NUM_CH-1:0][pwg_pkg::CMD_W-1:0]    command_in,
	input  wire logic [NUM_CH-1:0][pwg_pkg::SCALE_W-1:0]  scale_in,
	input  wire logic [NUM_CH-1:0][pwg_pkg::FREQ_W-1:0]   freq_req_in,
	input  wire logic [NUM_CH-1:0]                        dither_in,
	input  wire logic [NUM_CH-1:0][pwg_pkg::DUTY_W-1:0]   duty_floor_in,
	input  wire logic [NUM_CH-1:0][pwg_pkg::DUTY_W-1:0]   duty_ceiling_in,
	output logic      [NUM_CH-1:0]                        mod_out,
	output logic      [NUM_CH-1:0]                        dir_out,
	output logic      [NUM_CH-1:0]                        up_out,
	output logic      [NUM_CH-1:0]                        down_out,
	output logic      [NUM_CH-1:0][pwg_pkg::DUTY_W-1:0]   duty_readback_out,
	output logic      [NUM_CH-1:0][pwg_pkg::FREQ_W-1:0]   freq_eff_out
);
	localparam int CIW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
	localparam logic [16:0] ONE = pwg_pkg::DUTY_ONE;

	// magnitude of a command; style 0 drops negatives
	function automatic logic [15:0] cmd_mag(input logic [15:0] cmd, input logic [1:0] style);
		logic [15:0] m;
		m = cmd[15] ? 16'(-cmd) : cmd;
		if (cmd[15] && style == pwg_pkg::STYLE_PWM)
			m = 16'h0000;
		return m;
	endfunction

	// saturate, floor, ceiling and enable gating of a raw duty
	function automatic logic [16:0] duty_limit(input logic [31:0] q, input logic en,
		input logic [16:0] flo, input logic [16:0] ceil);
		logic [16:0] d;
		d = (q > 32'(ONE)) ? ONE : q[16:0];
		if (d < flo)
			d = flo;
		if (d > ceil)
			d = ceil;
		if (!en)
			d = 17'h00000;
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// base tick and slow update event, shared by all channels
	logic [15:0] tick_cnt_reg;
	logic        base_tick_reg;
	logic [15:0] slow_cnt_reg;
	logic        slow_go_reg;

	// base tick: every decision of the fast stage waits for it
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_cnt_reg  <= 16'h0000;
			base_tick_reg <= 1'b0;
		end else if (tick_cnt_reg == 16'(pwg_pkg::TICK_CYC - 1)) begin
			tick_cnt_reg  <= 16'h0000;
			base_tick_reg <= 1'b1;
		end else begin
			tick_cnt_reg  <= tick_cnt_reg + 16'h0001;
			base_tick_reg <= 1'b0;
		end
	end

	// slow update request, counted in base ticks
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			slow_cnt_reg <= 16'h0000;
			slow_go_reg  <= 1'b0;
		end else begin
			slow_go_reg <= 1'b0;
			if (base_tick_reg) begin
				if (slow_cnt_reg == 16'(SLOW_TICKS - 1)) begin
					slow_cnt_reg <= 16'h0000;
					slow_go_reg  <= 1'b1;
				end else
					slow_cnt_reg <= slow_cnt_reg + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slow update: channels walked in turn through one shared divider
	pwg_pkg::pwg_slow_t state_reg;
	logic [CIW-1:0]     ch_reg;
	logic               issued_reg;
	logic               div_start_reg;
	logic [31:0]        div_num_reg;
	logic [31:0]        div_den_reg;
	logic               div_done;
	logic [31:0]        div_q;
	logic [16:0]        duty_t_reg;
	logic [23:0]        perq_t_reg;
	logic [23:0]        freq_t_reg;
	logic [16:0]        rb_t_reg;
	logic [31:0]        num_c;
	logic [31:0]        den_c;
	logic               need_c;
	logic [23:0]        fc;
	logic [40:0]        prod;
	logic [15:0]        high_int;
	logic [23:0]        high_q_c;

	pwg_divider #(.W(pwg_pkg::DIV_W)) u_div (
		.mclk_in    (mclk_in),
		.reset_n_in (reset_n_in),
		.start_in   (div_start_reg),
		.num_in     (div_num_reg),
		.den_in     (div_den_reg),
		.done_out   (div_done),
		.quot_out   (div_q)
	);

	// clamped request and high time from period times duty
	assign fc       = (freq_req_in[ch_reg] > 24'(pwg_pkg::FREQ_MAX_HZ)) ?
		24'(pwg_pkg::FREQ_MAX_HZ) : freq_req_in[ch_reg];
	assign prod     = 41'(perq_t_reg) * 41'(duty_t_reg);
	assign high_int = 16'((prod + 41'h00000800000) >> 24);
	assign high_q_c = dither_in[ch_reg] ? prod[39:16] : {high_int, 8'h00};

	// divider operands for the current step
	always_comb begin
		need_c = 1'b1;
		num_c  = 32'h00000000;
		den_c  = 32'h00000001;
		case (state_reg)
			pwg_pkg::S_DUTY: begin
				num_c = {cmd_mag(command_in[ch_reg], style_in[ch_reg]), 16'h0000};
				den_c = 32'(scale_in[ch_reg]);
			end
			pwg_pkg::S_PER: begin
				need_c = (freq_req_in[ch_reg] != 24'h000000);
				num_c  = dither_in[ch_reg] ? 32'(pwg_pkg::TICK_HZ) << pwg_pkg::PER_FRAC :
					32'(pwg_pkg::TICK_HZ) + 32'(fc >> 1);
				den_c  = 32'(fc);
			end
			pwg_pkg::S_FREQ: begin
				num_c = 32'(pwg_pkg::TICK_HZ) + 32'(perq_t_reg[23:9]);
				den_c = 32'(perq_t_reg[23:8]);
			end
			pwg_pkg::S_RB: begin
				num_c = {high_int, 16'h0000};
				den_c = 32'(perq_t_reg[23:8]);
			end
			default: need_c = 1'b0;
		endcase
	end

	// one divide issued per step, cleared when it finishes
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			issued_reg    <= 1'b0;
			div_start_reg <= 1'b0;
			div_num_reg   <= 32'h00000000;
			div_den_reg   <= 32'h00000000;
		end else begin
			div_start_reg <= 1'b0;
			if (need_c && !issued_reg) begin
				issued_reg    <= 1'b1;
				div_start_reg <= 1'b1;
				div_num_reg   <= num_c;
				div_den_reg   <= den_c;
			end else if (div_done)
				issued_reg <= 1'b0;
		end
	end

	// sequencer; a slow event while busy is skipped, results just age one interval
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg  <= pwg_pkg::S_IDLE;
			ch_reg     <= '0;
			duty_t_reg <= 17'h00000;
			perq_t_reg <= 24'h000000;
			freq_t_reg <= 24'h000000;
			rb_t_reg   <= 17'h00000;
		end else begin
			case (state_reg)
				pwg_pkg::S_IDLE: begin
					ch_reg <= '0;
					if (slow_go_reg)
						state_reg <= pwg_pkg::S_DUTY;
				end
				pwg_pkg::S_DUTY: if (div_done && issued_reg) begin
					duty_t_reg <= duty_limit(div_q, enable_in[ch_reg],
						duty_floor_in[ch_reg], duty_ceiling_in[ch_reg]);
					state_reg  <= pwg_pkg::S_PER;
				end
				pwg_pkg::S_PER: if (freq_req_in[ch_reg] == 24'h000000) begin
					perq_t_reg <= 24'h000000;
					freq_t_reg <= 24'h000000;
					rb_t_reg   <= duty_t_reg;
					state_reg  <= pwg_pkg::S_NEXT;
				end else if (div_done && issued_reg) begin
					if (dither_in[ch_reg]) begin
						perq_t_reg <= div_q[23:0];
						freq_t_reg <= fc;
						rb_t_reg   <= duty_t_reg;
						state_reg  <= pwg_pkg::S_NEXT;
					end else begin
						perq_t_reg <= {div_q[15:0], 8'h00};
						state_reg  <= pwg_pkg::S_FREQ;
					end
				end
				pwg_pkg::S_FREQ: if (div_done && issued_reg) begin
					freq_t_reg <= div_q[23:0];
					state_reg  <= pwg_pkg::S_RB;
				end
				pwg_pkg::S_RB: if (div_done && issued_reg) begin
					rb_t_reg  <= (div_q > 32'(ONE)) ? ONE : div_q[16:0];
					state_reg <= pwg_pkg::S_NEXT;
				end
				pwg_pkg::S_NEXT: begin
					ch_reg    <= ch_reg + CIW'(1);
					state_reg <= (ch_reg == CIW'(NUM_CH - 1)) ? pwg_pkg::S_IDLE : pwg_pkg::S_DUTY;
				end
				default: state_reg <= pwg_pkg::S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// per-channel settings written at the end of each channel's update
	logic [NUM_CH-1:0][23:0] per_q_reg;
	logic [NUM_CH-1:0][23:0] high_q_reg;
	logic [NUM_CH-1:0][16:0] duty_reg;
	logic [NUM_CH-1:0]       neg_reg;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			per_q_reg         <= '0;
			high_q_reg        <= '0;
			duty_reg          <= '0;
			neg_reg           <= '0;
			duty_readback_out <= '0;
			freq_eff_out      <= '0;
		end else if (state_reg == pwg_pkg::S_NEXT) begin
			per_q_reg[ch_reg]         <= perq_t_reg;
			high_q_reg[ch_reg]        <= high_q_c;
			duty_reg[ch_reg]          <= duty_t_reg;
			neg_reg[ch_reg]           <= command_in[ch_reg][15];
			duty_readback_out[ch_reg] <= rb_t_reg;
			freq_eff_out[ch_reg]      <= freq_t_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// fast stage: every channel decides its level on each base tick
	logic [NUM_CH-1:0][15:0] pos_reg;
	logic [NUM_CH-1:0][16:0] cper_reg;
	logic [NUM_CH-1:0][16:0] chigh_reg;
	logic [NUM_CH-1:0][7:0]  pfr_reg;
	logic [NUM_CH-1:0][7:0]  hfr_reg;
	logic [NUM_CH-1:0][15:0] pdm_acc_reg;
	logic [NUM_CH-1:0]       mod_reg;

	always_ff @(posedge mclk_in or negedge reset_n_in) begin : fast
		logic [17:0] sum;
		logic [8:0]  pf;
		logic [8:0]  hf;
		logic [16:0] nxt;
		sum = 18'h00000;
		pf  = 9'h000;
		hf  = 9'h000;
		nxt = 17'h00000;
		if (!reset_n_in) begin
			pos_reg     <= '0;
			cper_reg    <= '0;
			chigh_reg   <= '0;
			pfr_reg     <= '0;
			hfr_reg     <= '0;
			pdm_acc_reg <= '0;
			mod_reg     <= '0;
		end else if (base_tick_reg) begin
			for (int c = 0; c < NUM_CH; c++) begin
				nxt = 17'(pos_reg[c]) + 17'h00001;
				if (!enable_in[c]) begin
					mod_reg[c] <= 1'b0;
					pos_reg[c] <= 16'h0000;
				end else if (per_q_reg[c] == 24'h000000) begin
					sum = 18'(pdm_acc_reg[c]) + 18'(duty_reg[c]);
					if (sum >= 18'(ONE)) begin
						mod_reg[c]     <= 1'b1;
						pdm_acc_reg[c] <= 16'(sum - 18'(ONE));
					end else begin
						mod_reg[c]     <= 1'b0;
						pdm_acc_reg[c] <= sum[15:0];
					end
				end else if (nxt >= cper_reg[c]) begin
					// fractions carry into whole ticks, zero when not dithering
					pf = 9'(pfr_reg[c]) + 9'(per_q_reg[c][7:0]);
					hf = 9'(hfr_reg[c]) + 9'(high_q_reg[c][7:0]);
					pfr_reg[c]   <= pf[7:0];
					hfr_reg[c]   <= hf[7:0];
					cper_reg[c]  <= 17'(per_q_reg[c][23:8]) + 17'(pf[8]);
					chigh_reg[c] <= 17'(high_q_reg[c][23:8]) + 17'(hf[8]);
					pos_reg[c]   <= 16'h0000;
					mod_reg[c]   <= (high_q_reg[c][23:8] != 16'h0000) | hf[8];
				end else begin
					pos_reg[c] <= nxt[15:0];
					mod_reg[c] <= (nxt < chigh_reg[c]);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin mapping by output style
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mod_out  <= '0;
			dir_out  <= '0;
			up_out   <= '0;
			down_out <= '0;
		end else begin
			for (int c = 0; c < NUM_CH; c++) begin
				mod_out[c]  <= 1'b0;
				dir_out[c]  <= 1'b0;
				up_out[c]   <= 1'b0;
				down_out[c] <= 1'b0;
				if (enable_in[c]) begin
					case (style_in[c])
						pwg_pkg::STYLE_PWM: mod_out[c] <= mod_reg[c];
						pwg_pkg::STYLE_PWM_DIR: begin
							mod_out[c] <= mod_reg[c];
							dir_out[c] <= neg_reg[c];
						end
						pwg_pkg::STYLE_UPDN: begin
							up_out[c]   <= mod_reg[c] & ~neg_reg[c];
							down_out[c] <= mod_reg[c] & neg_reg[c];
						end
						default: mod_out[c] <= 1'b0;
					endcase
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks on channels 0 to 5 and one on mod_reg of all channels; each channel check watches a channel set up so its antecedent really occurs
	if (NUM_CH >= 6) begin : g_chk
		sequence s_store(int k);
			state_reg == pwg_pkg::S_NEXT && ch_reg == k;
		endsequence
		sequence s_full_pdm;
			enable_in[3] && per_q_reg[3] == 24'h000000 && duty_reg[3] == ONE ##0 base_tick_reg;
		endsequence

		property p_disabled_low;
			@(posedge mclk_in) disable iff (!reset_n_in)
			!enable_in[1] |=> !mod_out[1] && !dir_out[1] && !up_out[1] && !down_out[1];
		endproperty
		a_disabled_low: assert property (p_disabled_low) else $error("disabled channel drives output");

		property p_style0_pins;
			@(posedge mclk_in) disable iff (!reset_n_in)
			style_in[0] == pwg_pkg::STYLE_PWM |=> !dir_out[0] && !up_out[0] && !down_out[0];
		endproperty
		a_style0_pins: assert property (p_style0_pins) else $error("style 0 drives foreign pin");

		property p_dir_sign;
			@(posedge mclk_in) disable iff (!reset_n_in)
			enable_in[1] && style_in[1] == pwg_pkg::STYLE_PWM_DIR |=> dir_out[1] == $past(neg_reg[1]);
		endproperty
		a_dir_sign: assert property (p_dir_sign) else $error("direction pin disagrees with sign");

		property p_updn;
			@(posedge mclk_in) disable iff (!reset_n_in)
			style_in[3] == pwg_pkg::STYLE_UPDN |=> !mod_out[3] && !(up_out[3] && down_out[3]);
		endproperty
		a_updn: assert property (p_updn) else $error("up/down style pins wrong");

		property p_ceiling;
			@(posedge mclk_in) disable iff (!reset_n_in)
			s_store(2) |=> duty_reg[2] <= $past(duty_ceiling_in[2]);
		endproperty
		a_ceiling: assert property (p_ceiling) else $error("duty above ceiling");

		property p_floor;
			@(posedge mclk_in) disable iff (!reset_n_in)
			s_store(0) ##0 (enable_in[0] && duty_floor_in[0] <= duty_ceiling_in[0])
				|=> duty_reg[0] >= $past(duty_floor_in[0]);
		endproperty
		a_floor: assert property (p_floor) else $error("duty below floor");

		property p_disabled_zero;
			@(posedge mclk_in) disable iff (!reset_n_in)
			s_store(4) ##0 !enable_in[4] |=> duty_reg[4] == 17'h00000;
		endproperty
		a_disabled_zero: assert property (p_disabled_zero) else $error("disabled duty not zero");

		property p_freq_max;
			@(posedge mclk_in) disable iff (!reset_n_in)
			s_store(5) |=> freq_eff_out[5] <= 24'(pwg_pkg::FREQ_MAX_HZ);
		endproperty
		a_freq_max: assert property (p_freq_max) else $error("effective frequency above limit");

		property p_tick_only;
			@(posedge mclk_in) disable iff (!reset_n_in)
			!base_tick_reg |=> $stable(mod_reg);
		endproperty
		a_tick_only: assert property (p_tick_only) else $error("modulation changed off tick");

		property p_full_pdm;
			@(posedge mclk_in) disable iff (!reset_n_in)
			s_full_pdm |=> mod_reg[3] ##1 (mod_out[3] || up_out[3] || down_out[3] || !enable_in[3]);
		endproperty
		a_full_pdm: assert property (p_full_pdm) else $error("full pdm duty not high");
	end
endmodule // pwg_pwm_pdm_gen

// ==== test/pwg_drive_model.sv ====
// behavioural power stage: records drive pulse lengths and which pins went high while measure_in is set
`timescale 1ns/1ns
module pwg_drive_model #(
	parameter int NUM_CH = 8
) (
	input  wire logic              mclk_in,
	input  wire logic              reset_n_in,
	input  wire logic              measure_in,
	input  wire logic [NUM_CH-1:0] mod_in,
	input  wire logic [NUM_CH-1:0] dir_in,
	input  wire logic [NUM_CH-1:0] up_in,
	input  wire logic [NUM_CH-1:0] down_in,
	output logic      [31:0]       hi_min_out [NUM_CH],
	output logic      [31:0]       hi_max_out [NUM_CH],
	output logic      [31:0]       lo_len_out [NUM_CH],
	output logic      [NUM_CH-1:0] seen_mod_out,
	output logic      [NUM_CH-1:0] seen_dir_out,
	output logic      [NUM_CH-1:0] seen_up_out,
	output logic      [NUM_CH-1:0] seen_down_out,
	output logic      [NUM_CH-1:0] seen_both_out
);
	logic [NUM_CH-1:0] drive;
	logic [NUM_CH-1:0] prev_reg;
	logic [NUM_CH-1:0] armed_reg;
	logic [31:0]       len_reg [NUM_CH];

	// the bridge sees power whenever any switching pin is high
	assign drive = mod_in | up_in | down_in;

	////////////////////////////////////////////////////////////////////////////////
	// pulse timing: only pulses that start inside the window count, so partial ones are ignored
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			prev_reg  <= '0;
			armed_reg <= '0;
			for (int c = 0; c < NUM_CH; c++) begin
				len_reg[c]    <= 32'h0;
				hi_min_out[c] <= 32'hFFFFFFFF;
				hi_max_out[c] <= 32'h0;
				lo_len_out[c] <= 32'h0;
			end
		end else begin
			prev_reg <= drive;
			for (int c = 0; c < NUM_CH; c++) begin
				if (measure_in && drive[c] != prev_reg[c]) begin
					if (armed_reg[c] && prev_reg[c]) begin
						if (len_reg[c] < hi_min_out[c]) hi_min_out[c] <= len_reg[c];
						if (len_reg[c] > hi_max_out[c]) hi_max_out[c] <= len_reg[c];
					end
					if (armed_reg[c] && !prev_reg[c]) lo_len_out[c] <= len_reg[c];
					armed_reg[c] <= 1'b1;
					len_reg[c]   <= 32'h1;
				end else begin
					len_reg[c] <= len_reg[c] + 32'h1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sticky pin activity, shoot-through would short the bridge
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			seen_mod_out  <= '0;
			seen_dir_out  <= '0;
			seen_up_out   <= '0;
			seen_down_out <= '0;
			seen_both_out <= '0;
		end else if (measure_in) begin
			seen_mod_out  <= seen_mod_out | mod_in;
			seen_dir_out  <= seen_dir_out | dir_in;
			seen_up_out   <= seen_up_out | up_in;
			seen_down_out <= seen_down_out | down_in;
			seen_both_out <= seen_both_out | (up_in & down_in);
		end
	end
endmodule // pwg_drive_model

// ==== test/tb_pwg_pwm_pdm_gen.sv ====
// self-checking testbench: eight channels configured at once, first slow update checked, later ones track a command change
`timescale 1ns/1ns
module tb_pwg_pwm_pdm_gen;
	localparam int          N    = 8;
	localparam int          SLOW = 10; // short slow interval keeps the run under the cycle budget
	localparam logic [31:0] SKIP = 32'hFFFFFFFF;
	localparam logic [15:0] CMD  [N] = '{16'hF830, 16'hF830, 16'h0FA0, 16'hFC18, 16'hF830, 16'h07D0, 16'h07D0, 16'h03E8};
	localparam logic [1:0]  STY  [N] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h1, 2'h0};
	localparam logic [23:0] FRQ  [N] = '{24'h001388, 24'h001388, 24'h001388, 24'h000000,
		24'h001388, 24'h989680, 24'h001770, 24'h001770};
	localparam logic [16:0] FLR  [N] = '{17'h04000, 17'h0, 17'h0, 17'h0, 17'h04000, 17'h0, 17'h0, 17'h0};
	localparam logic [31:0] E_RB [N] = '{32'h4000, 32'h8000, 32'hC000, 32'h4000, 32'h0, 32'h8000, 32'h8000, SKIP};
	localparam logic [31:0] E_FE [N] = '{32'h1388, 32'h1388, 32'h1388, 32'h0, SKIP, 32'hC350, 32'h1770, 32'h16FA};
	localparam logic [31:0] E_HI [N] = '{32'h1388, 32'h2710, 32'h3A98, 32'h3E8, SKIP, 32'h3E8, SKIP, 32'hFA0};
	localparam logic [31:0] E_LO [N] = '{32'h3A98, 32'h2710, 32'h1388, 32'hBB8, SKIP, 32'h3E8, SKIP, 32'h32C8};

	logic                       mclk_in;
	logic                       reset_n_in;
	logic                       measure;
	logic [N-1:0]               enable;
	logic [N-1:0]               dither;
	logic [N-1:0][1:0]          style;
	logic [N-1:0][15:0]         command;
	logic [N-1:0][15:0]         scale;
	logic [N-1:0][23:0]         freq_req;
	logic [N-1:0][16:0]         floor_f;
	logic [N-1:0][16:0]         ceil_f;
	logic [N-1:0]               mod_o;
	logic [N-1:0]               dir_o;
	logic [N-1:0]               up_o;
	logic [N-1:0]               down_o;
	logic [N-1:0][16:0]         readback;
	logic [N-1:0][23:0]         freq_eff;
	logic [31:0]                hi_min [N];
	logic [31:0]                hi_max [N];
	logic [31:0]                lo_len [N];
	logic [N-1:0]               s_mod;
	logic [N-1:0]               s_dir;
	logic [N-1:0]               s_up;
	logic [N-1:0]               s_dn;
	logic [N-1:0]               s_both;
	int                         error_cnt;
	int                         checks_done;

	pwg_pwm_pdm_gen #(.NUM_CH(N), .SLOW_TICKS(SLOW)) DUT (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
		.enable_in(enable), .style_in(style), .command_in(command), .scale_in(scale), .freq_req_in(freq_req),
		.dither_in(dither), .duty_floor_in(floor_f), .duty_ceiling_in(ceil_f), .mod_out(mod_o), .dir_out(dir_o),
		.up_out(up_o), .down_out(down_o), .duty_readback_out(readback), .freq_eff_out(freq_eff));

	pwg_drive_model #(.NUM_CH(N)) stage (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .measure_in(measure),
		.mod_in(mod_o), .dir_in(dir_o), .up_in(up_o), .down_in(down_o), .hi_min_out(hi_min), .hi_max_out(hi_max),
		.lo_len_out(lo_len), .seen_mod_out(s_mod), .seen_dir_out(s_dir), .seen_up_out(s_up),
		.seen_down_out(s_dn), .seen_both_out(s_both));

	// 100 MHz clock
	always #5 mclk_in = ~mclk_in;

	////////////////////////////////////////////////////////////////////////////////
	// one comparison, reported at once on mismatch
	task automatic chk(input string nm, input int ch, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s ch%0d expected %0h seen %0h", nm, ch, exp, got);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// outputs must stay quiet through reset
	task automatic test_reset();
		repeat (20) @(posedge mclk_in);
		@(negedge mclk_in);
		chk("pins", 0, 32'h0, 32'({mod_o, dir_o, up_o, down_o}));
		chk("readback", 0, 32'h0, 32'(readback[0]));
		reset_n_in = 1'b1;
		$display("test reset done");
	endtask

	// settle on effective duty and carrier after the first slow update of every channel
	task automatic test_levels();
		repeat (12500) @(posedge mclk_in);
		@(negedge mclk_in);
		for (int c = 0; c < N; c++) begin
			if (E_RB[c] !== SKIP) chk("readback", c, E_RB[c], 32'(readback[c]));
			if (E_FE[c] !== SKIP) chk("freq_eff", c, E_FE[c], 32'(freq_eff[c]));
		end
		$display("test levels done");
	endtask

	// pulse lengths in clocks prove tick-aligned high and low counts; a long window costs run time
	task automatic test_pulses();
		measure = 1'b1;
		repeat (70000) @(posedge mclk_in);
		@(negedge mclk_in);
		measure = 1'b0;
		for (int c = 0; c < N; c++) begin
			if (E_HI[c] !== SKIP) chk("hi_min", c, E_HI[c], hi_min[c]);
			if (E_HI[c] !== SKIP) chk("hi_max", c, E_HI[c], hi_max[c]);
			if (E_LO[c] !== SKIP) chk("lo_len", c, E_LO[c], lo_len[c]);
		end
		chk("dither span", 6, 32'h3E8, hi_max[6] - hi_min[6]);
		chk("seen mod", 0, 32'hE3, 32'(s_mod));
		chk("seen dir", 0, 32'h02, 32'(s_dir));
		chk("seen up", 0, 32'h04, 32'(s_up));
		chk("seen down", 0, 32'h08, 32'(s_dn));
		chk("shoot through", 0, 32'h0, 32'(s_both));
		$display("test pulses done");
	endtask

	// enable and style act directly, a pin must not wait for the next slow update
	task automatic test_direct();
		chk("dir before", 1, 32'h1, 32'(dir_o[1]));
		enable[1] = 1'b0;
		style[5]  = 2'h3;
		repeat (3) @(posedge mclk_in);
		@(negedge mclk_in);
		chk("dir off", 1, 32'h0, 32'(dir_o[1]));
		chk("mod off", 1, 32'h0, 32'(mod_o[1]));
		chk("style3 pins", 5, 32'h0, 32'({mod_o[5], dir_o[5], up_o[5], down_o[5]}));
		$display("test direct done");
	endtask

	// full negative command on the up/down pdm channel: down must stay high on every tick
	task automatic test_full_pdm();
		command[3] = 16'hF060;
		repeat (12000) @(posedge mclk_in);
		@(negedge mclk_in);
		chk("readback full", 3, 32'h10000, 32'(readback[3]));
		chk("up/down full", 3, 32'h1, 32'({up_o[3], down_o[3]}));
		repeat (1500) @(posedge mclk_in);
		@(negedge mclk_in);
		chk("up/down held", 3, 32'h1, 32'({up_o[3], down_o[3]}));
		$display("test full pdm done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// every input has a value at time zero, then the scenarios run in order
	initial begin
		mclk_in     = 1'b0;
		reset_n_in  = 1'b0;
		measure     = 1'b0;
		error_cnt   = 0;
		checks_done = 0;
		enable      = 8'hEF;
		dither      = 8'h40;
		for (int c = 0; c < N; c++) begin
			style[c]    = STY[c];
			command[c]  = CMD[c];
			scale[c]    = 16'h0FA0;
			freq_req[c] = FRQ[c];
			floor_f[c]  = FLR[c];
			ceil_f[c]   = (c == 2) ? 17'h0C000 : 17'h10000;
		end
		test_reset();
		test_levels();
		test_pulses();
		test_direct();
		test_full_pdm();
		complete_run();
	end
endmodule // tb_pwg_pwm_pdm_gen
